/* src/spi_supervision_pkg.sv */
// Shared constants, types and decode helpers for the serial frame supervisor.
package spi_supervision_pkg;

  // Device clock and derived timing.
  localparam int SYS_CLK_HZ  = 40_000_000;
  localparam int SYS_CLK_MHZ = SYS_CLK_HZ / 1_000_000;

  // The frame limit is a longest time, so its cycle count rounds down.
  localparam int FRAME_TIME_LIMIT_US = 1000;
  localparam int FRAME_LIMIT_CYCLES  = FRAME_TIME_LIMIT_US * SYS_CLK_MHZ;

  // The ready-high pulse is a least time, so its cycle count rounds up.
  localparam int READY_HIGH_PULSE_NS     = 1000;
  localparam int READY_HIGH_PULSE_CYCLES =
    (READY_HIGH_PULSE_NS * SYS_CLK_MHZ + 999) / 1000;

  // Frame geometry.
  localparam int WORD_BITS      = 24;
  localparam int MAX_READ_REGS  = 32;
  localparam int MAX_WRITE_REGS = 8;
  localparam int OUT_WORDS      = MAX_READ_REGS + 2;
  localparam int IN_WORDS       = MAX_WRITE_REGS + 3;
  localparam int CNT_W          = 6;
  localparam int TMO_W          = 24;
  localparam int PULSE_CNT_W    = 8;

  localparam logic [CNT_W-1:0] BASE_WORDS        = 6'h06;
  localparam logic [CNT_W-1:0] CMD_WORDS         = 6'h02;
  localparam logic [CNT_W-1:0] WRITE_EXTRA_WORDS = 6'h04;
  localparam logic [CNT_W-1:0] READ_EXTRA_WORDS  = 6'h03;
  localparam logic [CNT_W-1:0] VOLT_B_DONE_WORDS = 6'h05;

  // Command encodings.
  localparam logic [15:0] CMD_RESET        = 16'h0011;
  localparam logic [15:0] CMD_LOCK         = 16'h0555;
  localparam logic [15:0] CMD_UNLOCK       = 16'h0655;
  localparam logic [2:0]  CMD_WRITE_PREFIX = 3'h3;
  localparam logic [2:0]  CMD_READ_PREFIX  = 3'h5;

  // Register space sections.
  localparam logic [7:0] SEQ_RESULT_BASE = 8'h10;
  localparam logic [7:0] SEC0_END        = 8'h2F;
  localparam logic [7:0] SEC1_START      = 8'h40;
  localparam logic [7:0] SEC1_END        = 8'h7E;
  localparam logic [7:0] SEC2_START      = 8'h80;
  localparam logic [7:0] SEC2_END        = 8'hBE;
  localparam logic [7:0] SEC3_START      = 8'hC0;
  localparam logic [7:0] SEC3_END        = 8'hFE;
  localparam logic [7:0] CONV_CTRL_ADDR  = 8'h09;

  localparam int START_A_BIT      = 14;
  localparam int START_B_BIT      = 12;
  localparam int TIMEOUT_FLAG_BIT = 9;

  typedef enum logic [2:0] {
    CMD_KIND_NULL,
    CMD_KIND_RESET,
    CMD_KIND_LOCK,
    CMD_KIND_UNLOCK,
    CMD_KIND_WRITE,
    CMD_KIND_READ
  } cmd_kind_t;

  typedef struct packed {
    logic [23:0] cur_a;
    logic [23:0] cur_b;
    logic [23:0] volt_a;
    logic [23:0] volt_b;
  } conv_set_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [15:0] data;
  } reg_write_t;

  // Anything that is not a known command behaves as the no-op command.
  function automatic cmd_kind_t decode_cmd(input logic [15:0] w);
    if (w[15:13] == CMD_WRITE_PREFIX && w[4:3] == 2'h0) begin
      return CMD_KIND_WRITE;
    end else if (w[15:13] == CMD_READ_PREFIX) begin
      return CMD_KIND_READ;
    end else if (w == CMD_RESET) begin
      return CMD_KIND_RESET;
    end else if (w == CMD_LOCK) begin
      return CMD_KIND_LOCK;
    end else if (w == CMD_UNLOCK) begin
      return CMD_KIND_UNLOCK;
    end else begin
      return CMD_KIND_NULL;
    end
  endfunction

  function automatic logic addr_valid(input logic [7:0] a);
    return (a <= SEC0_END) ||
           (a >= SEC1_START && a <= SEC1_END) ||
           (a >= SEC2_START && a <= SEC2_END) ||
           (a >= SEC3_START && a <= SEC3_END);
  endfunction

  // Section 0 is read-only except for the self-clearing conversion control.
  function automatic logic addr_writable(input logic [7:0] a);
    return (a == CONV_CTRL_ADDR) || (addr_valid(a) && a >= SEC1_START);
  endfunction

endpackage

/* src/spi_frame_supervisor.sv */
// Serial frame timeout, partial-frame command gating and data-ready pin.
`timescale 1ns/1ps
// What this block does
// - Time each frame from chip select fall; report overtime in next status.
// - After a timeout, ignore further input bits until chip select rises.
// - Run overtime supervision only while the overtime enable input is set.
// - Timeout after a complete frame changes nothing but still sets the flag.
// - No-op does nothing; reset runs only once output checksum went out.
// - Lock, unlock, read run once command and checksum words arrived.
// - Write runs once command, checksum, data and data checksum arrived.
// - Timed-out frame releases ready only if voltage b word went out.
// - Next frame after a no-op returns the four converter results.
// - Sequence results live in registers from 10h, fetched by register reads.
// - One register read frame returns up to 32 consecutive registers.
// - Ready pin falls when the selected current converter completes.
// - If ready is still low on completion, pulse it high first.
// - Ready rises after voltage b word is shifted out, else stays low.
// - Repeated reads return the same results until new ones complete.
// - Results completing during a read wait and load in the next frame.
// - Waiting newer results keep the ready pin low after the old read.
// - An unread waiting set is replaced by the newest results.
// - Restart bit write raises ready at the end of the data checksum.
// - After restart, old results are served until new ones complete.
// - Decode 00h to FEh but for 30h-3Fh, 7Fh, BFh; section 0 holds status and results, read-only but for 09h.
// - Global, half A and half B configuration fill sections 1 to 3.
module spi_frame_supervisor #(
  parameter int unsigned FRAME_LIMIT_CYCLES =
    spi_supervision_pkg::FRAME_LIMIT_CYCLES,
  parameter int unsigned PULSE_CYCLES =
    spi_supervision_pkg::READY_HIGH_PULSE_CYCLES,
  parameter int unsigned WORD_BITS = spi_supervision_pkg::WORD_BITS
) (
  input  wire logic                           sys_clk_i,
  input  wire logic                           sys_rst_i,
  input  wire logic                           spi_sclk_i,
  input  wire logic                           cs_n_i,
  input  wire logic                           sdi_i,
  output logic                                sdo_o,
  output logic                                sdo_oe_o,
  input  wire logic                           frame_overtime_enable_i,
  input  wire logic                           ready_source_select_i,
  input  wire spi_supervision_pkg::conv_set_t conv_i,
  input  wire logic                           cur_a_done_i,
  input  wire logic                           cur_b_done_i,
  input  wire logic [15:0]                    status_i,
  input  wire logic [WORD_BITS-1:0]           out_crc_i,
  output logic [7:0]                          reg_rd_addr_o,
  input  wire logic [15:0]                    reg_rd_data_i,
  output spi_supervision_pkg::reg_write_t     reg_wr_o,
  output logic                                write_refused_o,
  output logic                                device_reset_o,
  output logic                                conversion_restart_o,
  output logic                                interface_locked_o,
  output logic                                sample_ready_pin_n_o,
  output logic                                frame_overtime_flag_n_o
);

  localparam int CW = spi_supervision_pkg::CNT_W;

  if (WORD_BITS != 24 && WORD_BITS != 32) begin : g_chk_word
    $error("WORD_BITS must be 24 or 32");
  end
  if (FRAME_LIMIT_CYCLES < 1 ||
      FRAME_LIMIT_CYCLES >= (1 << spi_supervision_pkg::TMO_W)) begin : g_chk_t
    $error("FRAME_LIMIT_CYCLES out of range");
  end
  if (PULSE_CYCLES < 1 ||
      PULSE_CYCLES > (1 << spi_supervision_pkg::PULSE_CNT_W)) begin : g_chk_p
    $error("PULSE_CYCLES out of range");
  end

  function automatic logic [CW-1:0] to_gray(input logic [CW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [CW-1:0] from_gray(input logic [CW-1:0] g);
    logic [CW-1:0] b;
    b = '0;
    for (int i = CW - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == CW - 1) ? 1'b0 : b[i+1]);
    end
    return b;
  endfunction

  // Places a 24-bit value at the top of a word; 32-bit words pad low.
  function automatic logic [WORD_BITS-1:0] align24(input logic [23:0] v);
    logic [31:0] t;
    t = {v, 8'h00};
    return t[31 -: WORD_BITS];
  endfunction

  // ---------------------------------------------------------------- link side
  // The serial clock stops between frames, so the counters and the expiry sync here are
  // cleared by chip select itself rather than by the device reset.
  logic [4:0]           bit_q;
  logic [CW-1:0]        word_cnt_q;
  logic [CW-1:0]        word_gray_q;
  logic [WORD_BITS-1:0] shift_q;
  logic [2:0]           exp_sync_q;
  logic                 exp_link_q;
  logic [15:0]          in_words [0:spi_supervision_pkg::IN_WORDS-1];
  logic [WORD_BITS-1:0] out_words_q [0:spi_supervision_pkg::OUT_WORDS-1];
  logic [CW-1:0]        out_len_q;
  logic                 expired_q;
  logic                 word_end;
  logic [WORD_BITS-1:0] rx_word;

  assign word_end = (bit_q == 5'(WORD_BITS - 1));
  assign rx_word  = {shift_q[WORD_BITS-2:0], sdi_i};

  always_ff @(negedge spi_sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_q       <= 5'h00;
      word_cnt_q  <= '0;
      word_gray_q <= '0;
    end else if (word_end) begin
      bit_q <= 5'h00;
      if (word_cnt_q != '1) begin
        word_cnt_q  <= word_cnt_q + 6'h01;
        word_gray_q <= to_gray(word_cnt_q + 6'h01);
      end
    end else begin
      bit_q <= bit_q + 5'h01;
    end
  end

  always_ff @(negedge spi_sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      exp_sync_q <= 3'h0;
      exp_link_q <= 1'b0;
    end else begin
      exp_sync_q <= {exp_sync_q[1:0], expired_q};
      if (exp_sync_q[1] == exp_sync_q[2]) begin
        exp_link_q <= exp_sync_q[2];
      end
    end
  end

  always_ff @(negedge spi_sclk_i) begin
    if (!cs_n_i && !exp_link_q) begin
      shift_q <= rx_word;
    end
  end

  always_ff @(negedge spi_sclk_i) begin
    if (!cs_n_i && !exp_link_q && word_end &&
        word_cnt_q < CW'(spi_supervision_pkg::IN_WORDS)) begin
      in_words[word_cnt_q[3:0]] <= rx_word[WORD_BITS-1 -: 16];
    end
  end

  // The output buffer is only rewritten while chip select is high, so it is
  // stable for the whole frame and safe to read from this clock.
  assign sdo_oe_o = ~cs_n_i;
  assign sdo_o    = (!cs_n_i && word_cnt_q < out_len_q) ?
                    out_words_q[word_cnt_q][5'(WORD_BITS - 1) - bit_q] : 1'b0;

  // -------------------------------------------------------------- device side
  logic [2:0]    cs_sync_q;
  logic          cs_low_q;
  logic          cs_low_d;
  logic [CW-1:0] gs1_q;
  logic [CW-1:0] gs2_q;
  logic [CW-1:0] gs3_q;
  logic          frame_start;
  logic          frame_end;
  logic          idle;

  assign cs_low_d    = (cs_sync_q[1] == cs_sync_q[2]) ? ~cs_sync_q[2]
                                                      : cs_low_q;
  assign frame_start = cs_low_d & ~cs_low_q;
  assign frame_end   = ~cs_low_d & cs_low_q;
  assign idle        = ~cs_low_d & ~cs_low_q;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cs_sync_q <= 3'h7;
      cs_low_q  <= 1'b0;
      gs1_q     <= '0;
      gs2_q     <= '0;
      gs3_q     <= '0;
    end else begin
      cs_sync_q <= {cs_sync_q[1:0], cs_n_i};
      cs_low_q  <= cs_low_d;
      gs1_q     <= word_gray_q;
      gs2_q     <= gs1_q;
      gs3_q     <= gs2_q;
    end
  end

  logic [spi_supervision_pkg::TMO_W-1:0] tmo_cnt_q;
  logic                                  flag_n_q;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || frame_start) begin
      tmo_cnt_q <= '0;
      expired_q <= 1'b0;
    end else if (cs_low_q && frame_overtime_enable_i && !expired_q) begin
      if (tmo_cnt_q ==
          spi_supervision_pkg::TMO_W'(FRAME_LIMIT_CYCLES - 1)) begin
        expired_q <= 1'b1;
      end else begin
        tmo_cnt_q <= tmo_cnt_q + 1'b1;
      end
    end
  end

  // The flag is sampled at the close of a frame and stands through the next.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      flag_n_q <= 1'b1;
    end else if (frame_end) begin
      flag_n_q <= ~expired_q;
    end
  end

  // Word progress is frozen at expiry, so every milestone below counts only
  // words that were complete before the timeout.
  logic [CW-1:0] words_seen_q;
  logic [CW-1:0] word_now;

  assign word_now = from_gray(gs3_q);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || frame_start) begin
      words_seen_q <= '0;
    end else if (cs_low_d && !expired_q && gs2_q == gs3_q &&
                 word_now > words_seen_q) begin
      words_seen_q <= word_now;
    end
  end

  logic                           cmd_seen_q;
  logic [15:0]                    cmd_q;
  logic                           exec_done_q;
  logic                           lock_q;
  logic [CW-1:0]                  need;
  logic                           allowed;
  logic                           exec;
  spi_supervision_pkg::cmd_kind_t kind;

  assign kind = spi_supervision_pkg::decode_cmd(cmd_q);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || frame_start) begin
      cmd_seen_q <= 1'b0;
      cmd_q      <= 16'h0000;
    end else if (!cmd_seen_q && words_seen_q != '0) begin
      cmd_seen_q <= 1'b1;
      cmd_q      <= in_words[0];
    end
  end

  always_comb begin
    case (kind)
      spi_supervision_pkg::CMD_KIND_RESET:  need = out_len_q;
      spi_supervision_pkg::CMD_KIND_WRITE:
        need = CW'(cmd_q[2:0]) + spi_supervision_pkg::WRITE_EXTRA_WORDS;
      spi_supervision_pkg::CMD_KIND_LOCK,
      spi_supervision_pkg::CMD_KIND_UNLOCK,
      spi_supervision_pkg::CMD_KIND_READ:
        need = spi_supervision_pkg::CMD_WORDS;
      default: need = '1;
    endcase
  end

  assign allowed = !lock_q || kind == spi_supervision_pkg::CMD_KIND_READ ||
                   kind == spi_supervision_pkg::CMD_KIND_UNLOCK;
  assign exec = cmd_seen_q && !exec_done_q && allowed &&
                kind != spi_supervision_pkg::CMD_KIND_NULL &&
                words_seen_q >= need;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || frame_start) begin
      exec_done_q <= 1'b0;
    end else if (exec) begin
      exec_done_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      device_reset_o <= 1'b0;
      lock_q         <= 1'b0;
    end else begin
      device_reset_o <= exec && kind == spi_supervision_pkg::CMD_KIND_RESET;
      if (exec && kind == spi_supervision_pkg::CMD_KIND_LOCK) begin
        lock_q <= 1'b1;
      end else if (exec && (kind == spi_supervision_pkg::CMD_KIND_UNLOCK ||
                            kind == spi_supervision_pkg::CMD_KIND_RESET)) begin
        lock_q <= 1'b0;
      end
    end
  end

  assign interface_locked_o = lock_q;

  // Register writes leave one per cycle after the write command executes.
  logic       wr_busy_q;
  logic [2:0] wr_idx_q;
  logic [2:0] wr_last_q;
  logic [7:0] wr_base_q;
  logic [7:0] wr_addr;
  logic [15:0] wr_data;
  logic       wr_ok;

  assign wr_addr = wr_base_q + 8'(wr_idx_q);
  assign wr_data = in_words[4'(wr_idx_q) + 4'h2];
  assign wr_ok   = spi_supervision_pkg::addr_writable(wr_addr);

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wr_busy_q <= 1'b0;
      wr_idx_q  <= 3'h0;
      wr_last_q <= 3'h0;
      wr_base_q <= 8'h00;
    end else if (exec && kind == spi_supervision_pkg::CMD_KIND_WRITE) begin
      wr_busy_q <= 1'b1;
      wr_idx_q  <= 3'h0;
      wr_last_q <= cmd_q[2:0];
      wr_base_q <= cmd_q[12:5];
    end else if (wr_busy_q) begin
      wr_idx_q <= wr_idx_q + 3'h1;
      if (wr_idx_q == wr_last_q) begin
        wr_busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      reg_wr_o             <= '0;
      write_refused_o      <= 1'b0;
      conversion_restart_o <= 1'b0;
    end else begin
      reg_wr_o.valid       <= wr_busy_q && wr_ok;
      reg_wr_o.addr        <= wr_addr;
      reg_wr_o.data        <= wr_data;
      write_refused_o      <= wr_busy_q && !wr_ok;
      conversion_restart_o <= wr_busy_q &&
        wr_addr == spi_supervision_pkg::CONV_CTRL_ADDR &&
        (wr_data[spi_supervision_pkg::START_A_BIT] ||
         wr_data[spi_supervision_pkg::START_B_BIT]);
    end
  end

  // Result sets: one served set and one waiting set.
  spi_supervision_pkg::conv_set_t cur_q;
  spi_supervision_pkg::conv_set_t pend_q;
  logic                           pend_valid_q;
  logic                           new_evt;

  assign new_evt = ready_source_select_i ? cur_b_done_i : cur_a_done_i;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cur_q        <= '0;
      pend_q       <= '0;
      pend_valid_q <= 1'b0;
    end else begin
      if (new_evt) begin
        pend_q       <= conv_i;
        pend_valid_q <= 1'b1;
      end else if (idle && pend_valid_q) begin
        pend_valid_q <= 1'b0;
      end
      if (idle && pend_valid_q) begin
        cur_q <= pend_q;
      end
    end
  end

  // Output buffer: register read data after a read command, else results.
  logic        rd_pend_q;
  logic [4:0]  rd_idx_q;
  logic [4:0]  rd_last_q;
  logic [7:0]  rd_addr_q;
  logic        serve_read_q;
  logic [15:0] status_word;
  logic        rd_ok;

  assign rd_ok         = spi_supervision_pkg::addr_valid(rd_addr_q);
  assign reg_rd_addr_o = rd_addr_q;

  always_comb begin
    status_word = status_i;
    status_word[spi_supervision_pkg::TIMEOUT_FLAG_BIT] = flag_n_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rd_pend_q    <= 1'b0;
      rd_idx_q     <= 5'h00;
      rd_last_q    <= 5'h00;
      rd_addr_q    <= 8'h00;
      serve_read_q <= 1'b0;
      out_len_q    <= spi_supervision_pkg::BASE_WORDS;
    end else begin
      if (frame_end) begin
        serve_read_q <= 1'b0;
      end
      if (exec && kind == spi_supervision_pkg::CMD_KIND_READ) begin
        rd_pend_q <= 1'b1;
        rd_idx_q  <= 5'h00;
        rd_last_q <= cmd_q[4:0];
        rd_addr_q <= cmd_q[12:5];
      end else if (idle) begin
        out_words_q[0] <= align24({status_word, 8'h00});
        if (rd_pend_q) begin
          out_words_q[CW'(rd_idx_q) + 6'h01] <=
            rd_ok ? align24({reg_rd_data_i, rd_addr_q}) : '0;
          rd_idx_q  <= rd_idx_q + 5'h01;
          rd_addr_q <= rd_addr_q + 8'h01;
          if (rd_idx_q == rd_last_q) begin
            rd_pend_q    <= 1'b0;
            serve_read_q <= 1'b1;
            out_len_q    <= CW'(rd_last_q) +
                            spi_supervision_pkg::READ_EXTRA_WORDS;
            out_words_q[CW'(rd_last_q) + 6'h02] <= out_crc_i;
          end
        end else if (!serve_read_q) begin
          out_words_q[1] <= align24(cur_q.cur_a);
          out_words_q[2] <= align24(cur_q.cur_b);
          out_words_q[3] <= align24(cur_q.volt_a);
          out_words_q[4] <= align24(cur_q.volt_b);
          out_words_q[5] <= out_crc_i;
          out_len_q      <= spi_supervision_pkg::BASE_WORDS;
        end
      end
    end
  end

  // Data-ready pin.
  logic                                        ready_n_q;
  logic                                        pulse_q;
  logic [spi_supervision_pkg::PULSE_CNT_W-1:0] pulse_cnt_q;
  logic                                        rel_done_q;
  logic                                        release_ok;

  // Release only inside a frame: once chip select is high, a waiting set
  // moving up or a read-data frame closing must not free the pin.
  assign release_ok = !rel_done_q && !serve_read_q && !pend_valid_q &&
                      cs_low_q && words_seen_q >=
                      spi_supervision_pkg::VOLT_B_DONE_WORDS;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || frame_start) begin
      rel_done_q <= 1'b0;
    end else if (release_ok) begin
      rel_done_q <= 1'b1;
    end
  end

  // A device reset pulls the pin low at once; a new result outranks the
  // release so that a fresh set is never reported as already read.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ready_n_q   <= 1'b1;
      pulse_q     <= 1'b0;
      pulse_cnt_q <= '0;
    end else if (device_reset_o) begin
      ready_n_q <= 1'b0;
      pulse_q   <= 1'b0;
    end else if (new_evt) begin
      if (!ready_n_q || pulse_q) begin
        ready_n_q   <= 1'b1;
        pulse_q     <= 1'b1;
        pulse_cnt_q <= spi_supervision_pkg::PULSE_CNT_W'(PULSE_CYCLES - 1);
      end else begin
        ready_n_q <= 1'b0;
      end
    end else if (pulse_q) begin
      if (pulse_cnt_q == '0) begin
        ready_n_q <= 1'b0;
        pulse_q   <= 1'b0;
      end else begin
        pulse_cnt_q <= pulse_cnt_q - 1'b1;
      end
    end else if (conversion_restart_o || release_ok) begin
      ready_n_q <= 1'b1;
    end
  end

  assign sample_ready_pin_n_o    = ready_n_q;
  assign frame_overtime_flag_n_o = flag_n_q;

endmodule

/* verification/spi_frame_props.sv */
// Port checks for the frame supervisor, bound into the design.
`timescale 1ns/1ps
module spi_frame_props #(
  parameter int unsigned FRAME_LIMIT_CYCLES = 400
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic cs_n_i,
  input wire logic ready_source_select_i,
  input wire logic cur_a_done_i,
  input wire logic device_reset_o,
  input wire logic conversion_restart_o,
  input wire logic interface_locked_o,
  input wire logic sample_ready_pin_n_o,
  input wire logic frame_overtime_flag_n_o
);
  logic [15:0] cnt_q;
  logic [15:0] len_q;
  // The length of the last frame is kept so a late flag can be judged.
  always_ff @(posedge sys_clk_i) begin
    cnt_q <= cs_n_i ? 16'h0000 : cnt_q + 16'h0001;
    if (!cs_n_i) len_q <= cnt_q + 16'h0001;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence sel_a_s;
    !ready_source_select_i && cur_a_done_i;
  endsequence
  sequence hi4_s;
    sample_ready_pin_n_o [*4] ##1 !sample_ready_pin_n_o;
  endsequence
  AST_RDY_FALL: assert property (sel_a_s and sample_ready_pin_n_o
    |=> !sample_ready_pin_n_o) else $error("ready pin did not fall");
  AST_RDY_PULSE: assert property (sel_a_s and !sample_ready_pin_n_o
    |=> hi4_s) else $error("ready pin pulse wrong");
  AST_RESTART_HIGH: assert property (conversion_restart_o
    |=> sample_ready_pin_n_o) else $error("restart left pin low");
  AST_RESET_LOW: assert property (device_reset_o
    |-> ##[0:1] !sample_ready_pin_n_o) else $error("reset left pin high");
  AST_RESET_UNLOCK: assert property (device_reset_o
    |=> !interface_locked_o) else $error("reset kept the lock");
  AST_FLAG_LONG: assert property ($fell(frame_overtime_flag_n_o)
    |-> len_q > FRAME_LIMIT_CYCLES - 8) else $error("flag on short frame");
  AST_FLAG_AT_END: assert property ($changed(frame_overtime_flag_n_o)
    |-> cs_n_i) else $error("flag moved inside a frame");
  AST_LOCK_NORESET: assert property (interface_locked_o &&
    $past(interface_locked_o) |-> !device_reset_o) else $error("reset ran");
endmodule
bind spi_frame_supervisor spi_frame_props #(
  .FRAME_LIMIT_CYCLES(FRAME_LIMIT_CYCLES)
) props (.sys_clk_i, .sys_rst_i, .cs_n_i, .ready_source_select_i,
  .cur_a_done_i, .device_reset_o, .conversion_restart_o,
  .interface_locked_o, .sample_ready_pin_n_o, .frame_overtime_flag_n_o);

/* verification/spi_host_model.sv */
// Host controller model driving the serial link in mode 1.
`timescale 1ns/1ps
module spi_host_model (
  output logic     cs_n_o,
  output logic     sclk_o,
  output logic     sdi_o,
  input wire logic sdo_i
);
  logic [23:0] rx_q [0:39];
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b1;
  end
  // The clock parks low between frames; the released data line flips.
  task automatic xfer(input int nw, input logic [23:0] w0, w2,
                      input int pre, post);
    logic [23:0] w;
    cs_n_o = 1'b0;
    #(100 + pre);
    for (int i = 0; i < nw; i++) begin
      w = (i == 0) ? w0 : (i == 2) ? w2 : 24'h000000;
      for (int b = 23; b >= 0; b--) begin
        sclk_o = 1'b1;
        sdi_o = w[b];
        #24;
        rx_q[i][b] = sdo_i;
        sclk_o = 1'b0;
        #24;
      end
    end
    #(100 + post);
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #1200;
  endtask
endmodule

/* verification/spi_frame_supervisor_tb.sv */
// Self-checking bench for the frame supervisor.
`timescale 1ns/1ps
module spi_frame_supervisor_tb;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic en = 1'b0;
  logic sel = 1'b0;
  logic da = 1'b0;
  logic db = 1'b0;
  logic [15:0] status = 16'hFFFF;
  logic [23:0] crc = 24'h000000;
  spi_supervision_pkg::conv_set_t conv = '0;
  spi_supervision_pkg::reg_write_t wr;
  logic cs_n_i, spi_sclk_i, sdi_i, sdo_o, pin_n, flag_n, locked, rs, rst;
  logic refused, oe;
  logic [7:0] rd_addr;
  logic [3:0] seen = 4'h0;
  logic [7:0] ad [5] = '{8'h10, 8'h2F, 8'h40, 8'h80, 8'hC0};
  logic [29:0] exp_q [$];
  logic [29:0] n;
  int mismatches = 0;
  int samples_checked = 0;
  spi_frame_supervisor #(.FRAME_LIMIT_CYCLES(400), .PULSE_CYCLES(4)) dut (
    .sys_clk_i, .sys_rst_i, .spi_sclk_i, .cs_n_i, .sdi_i, .sdo_o,
    .sdo_oe_o(oe), .frame_overtime_enable_i(en), .ready_source_select_i(sel),
    .conv_i(conv), .cur_a_done_i(da), .cur_b_done_i(db), .status_i(status),
    .out_crc_i(crc), .reg_rd_addr_o(rd_addr),
    .reg_rd_data_i({8'hC3, rd_addr}), .reg_wr_o(wr),
    .write_refused_o(refused), .device_reset_o(rst),
    .conversion_restart_o(rs), .interface_locked_o(locked),
    .sample_ready_pin_n_o(pin_n), .frame_overtime_flag_n_o(flag_n));
  spi_host_model h (.cs_n_o(cs_n_i), .sclk_o(spi_sclk_i), .sdi_o(sdi_i),
    .sdo_i(sdo_o));
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) seen <= seen | {rs, rst, wr.valid, refused};
  task automatic chk(input logic [23:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic done(input logic b);
    @(posedge sys_clk_i) #2;
    conv = {$urandom, $urandom, $urandom};
    {sel, da, db} = {b, !b, b};
    @(posedge sys_clk_i) #2;
    {da, db} = 2'b00;
    repeat (12) @(posedge sys_clk_i);
  endtask
  // A note is pushed just before its frame, so the frame end that pops it is its own.
  initial forever begin
    @(posedge cs_n_i);
    if (exp_q.size() != 0) begin
      n = exp_q.pop_front();
      chk(h.rx_q[n[29:24]], n[23:0]);
    end
  end
  initial begin
    #500_000;
    mismatches++;
    final_report();
  end
  initial begin
    void'($urandom(70));
    status = 16'($urandom);
    crc = 24'($urandom);
    repeat (8) @(posedge sys_clk_i);
    #2 sys_rst_i = 1'b0;
    repeat (20) @(posedge sys_clk_i);
    done(0); chk({oe, pin_n}, 0);
    exp_q.push_back({6'd1, conv.cur_a}); h.xfer(6, 0, 0, 0, 0);
    chk(pin_n, 1);
    done(1); h.xfer(4, 0, 0, 0, 0); chk(pin_n, 0);
    exp_q.push_back({6'd2, conv.cur_b}); h.xfer(6, 0, 0, 0, 0);
    done(0); done(0); chk(pin_n, 0);
    exp_q.push_back({6'd3, conv.volt_a}); h.xfer(6, 0, 0, 0, 0);
    exp_q.push_back({6'd1, conv.cur_a});
    fork h.xfer(6, 0, 0, 0, 0); #3000 done(0); join
    chk(pin_n, 0);
    exp_q.push_back({6'd1, conv.cur_a}); h.xfer(6, 0, 0, 0, 0);
    en = 1'b1;
    done(0); h.xfer(6, 0, 0, 0, 6000); chk({pin_n, flag_n}, 2'b10);
    exp_q.push_back({6'h00, status & 16'hFDFF, 8'h00});
    done(0); h.xfer(2, 0, 0, 0, 12000); chk({pin_n, flag_n}, 2'b00);
    en = 1'b0; h.xfer(2, 0, 0, 0, 12000); chk(flag_n, 1);
    en = 1'b1; h.xfer(2, 24'h055500, 0, 0, 12000); chk(locked, 1);
    h.xfer(2, 24'h065500, 0, 12000, 0); chk(locked, 1);
    h.xfer(2, 24'h065500, 0, 0, 0); chk(locked, 0);
    seen = 4'h0; h.xfer(4, 24'h612000, 24'h400000, 0, 0);
    chk({seen[3], pin_n}, 2'b11);
    exp_q.push_back({6'd1, conv.cur_a}); h.xfer(6, 0, 0, 0, 0);
    foreach (ad[i]) begin
      seen = 4'h0;
      h.xfer(4, {16'h6000 | {ad[i], 5'h00}, 8'h00}, 24'h123400, 0, 0);
      chk(seen[1:0], ad[i] < 8'h40 ? 2'b01 : 2'b10);
    end
    h.xfer(2, 24'hA21F00, 0, 0, 0);
    exp_q.push_back({6'd32, 24'hC32F2F}); h.xfer(34, 0, 0, 0, 0);
    seen = 4'h0; h.xfer(5, 24'h001100, 0, 0, 0); chk(seen[2], 0);
    h.xfer(6, 24'h001100, 0, 0, 0); chk(seen[2], 1);
    final_report();
  end
endmodule
